// ===== shared/ptw_cfg.svh
// constants of the bus target with wake event
`ifndef PTW_CFG_SVH
`define PTW_CFG_SVH
`define PTW_CLK_MAX_KHZ 66670
`define PTW_CLK_KHZ 25000
// identification values below are arbitrary
`define PTW_VENDOR_ID 16'h1A2B
`define PTW_DEVICE_ID 16'h3C4D
`define PTW_CLASS_REV 32'h07000200
`define PTW_CFG_ID 6'h00
`define PTW_CFG_CMD 6'h01
`define PTW_CFG_CLASS 6'h02
`define PTW_CFG_BAR0 6'h04
`define PTW_CFG_CAPP 6'h0D
`define PTW_CFG_INT 6'h0F
`define PTW_CFG_PMC 6'h10
`define PTW_CFG_PMCSR 6'h11
`define PTW_CAP_OFFS 8'h40
`define PTW_PMC_VALUE 32'h7E030001
`define PTW_INT_PIN 8'h01
`define PTW_CMD_MEM 1
`define PTW_CMD_PERR 6
`define PTW_CMD_SERR 8
`define PTW_CMD_INTDIS 10
`define PTW_ST_DPERR 15
`define PTW_ST_SSERR 14
`define PTW_ST_INT 3
`define PTW_PM_EN 8
`define PTW_PM_ST 15
`define PTW_D3HOT 2'h3
`define PTW_D0 2'h0
`define PTW_MEM_GLOBAL 10'h020
`define PTW_CHANNEL_FUNCTION_CONTROL_IRINV 4
`define PTW_MCR_RTS 1
`define PTW_MCR_IRMODE 6
`define PTW_BUS_CFG_RD 4'hA
`define PTW_BUS_CFG_WR 4'hB
`define PTW_BUS_MEM_RD 4'h6
`define PTW_BUS_MEM_WR 4'h7
`define PTW_CMD_RESET 16'h0000
`define PTW_RX_IDLE 8'hFF
`endif

// ===== shared/ptw_pkg.sv
// types of the bus target with wake event
package ptw_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CLAIM,
        ST_DATA,
        ST_TURN
    } ptw_state_type;

    typedef struct packed {
        ptw_state_type st;
        logic frame_n;
        logic [31:0] addr;
        logic [3:0] cmd;
        logic is_cfg;
        logic [31:0] ad_o;
        logic ad_oe;
        logic par_o;
        logic par_oe;
        logic devsel_n;
        logic trdy_n;
        logic stop_n;
        logic ctl_oe;
        logic apar;
        logic apar_chk;
        logic dpar;
        logic dpar_chk;
        logic [1:0] perr_cnt;
        logic serr;
        logic [15:0] cmd_reg;
        logic det_perr;
        logic sig_serr;
        logic [19:0] bar;
        logic [7:0] int_line;
        logic [1:0] pstate;
        logic pme_en;
        logic pme_st;
        logic [7:0][7:0] channel_function_control;
        logic [7:0][7:0] mcr;
        logic [7:0] pend;
        logic [7:0] ien;
        logic [7:0] rx_out;
    } ptw_regs_type;
endpackage

// ===== design/ptw_target.sv
// bus target: config space, channel controls, parity, interrupt, wake
`timescale 1ns/1ps

module ptw_target (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [31:0] ad_i,
    output logic [31:0] ad_o,
    output logic ad_oe_n_o,
    input wire logic [3:0] cbe_n_i,
    input wire logic par_i,
    output logic par_o,
    output logic par_oe_n_o,
    input wire logic frame_n_i,
    input wire logic irdy_n_i,
    input wire logic idsel_i,
    output logic devsel_n_o,
    output logic devsel_oe_n_o,
    output logic trdy_n_o,
    output logic trdy_oe_n_o,
    output logic stop_n_o,
    output logic stop_oe_n_o,
    output logic perr_n_o,
    output logic perr_oe_n_o,
    output logic serr_n_o,
    output logic serr_oe_n_o,
    output logic inta_n_o,
    output logic inta_oe_n_o,
    output logic pme_n_o,
    output logic pme_oe_n_o,
    input wire logic [7:0] rx_char_i,
    input wire logic [7:0] modem_chg_i,
    input wire logic [7:0] rx_i,
    output logic [7:0] rx_dec_o,
    output logic [7:0] rts_n_o
);
`include "ptw_cfg.svh"

    ptw_pkg::ptw_regs_type q;
    ptw_pkg::ptw_regs_type d;

    // ========================================================
    // reset image, a constant so the async branch loads no logic
    localparam ptw_pkg::ptw_regs_type rst_val = '{
        st: ptw_pkg::ST_IDLE,
        frame_n: 1'b1,
        devsel_n: 1'b1,
        trdy_n: 1'b1,
        stop_n: 1'b1,
        cmd_reg: `PTW_CMD_RESET,
        pstate: `PTW_D0,
        rx_out: `PTW_RX_IDLE,
        default: '0
    };

    // ========================================================
    // read mux
    function automatic logic [31:0] cfg_rd(input ptw_pkg::ptw_regs_type r,
                                           input logic [5:0] idx);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (idx)
            `PTW_CFG_ID: v = {`PTW_DEVICE_ID, `PTW_VENDOR_ID};
            `PTW_CFG_CMD: begin
                v = {r.det_perr, r.sig_serr, 10'h001, |(r.pend & r.ien),
                     3'h0, r.cmd_reg};
            end
            `PTW_CFG_CLASS: v = `PTW_CLASS_REV;
            `PTW_CFG_BAR0: v = {r.bar, 12'h000};
            `PTW_CFG_CAPP: v = {24'h000000, `PTW_CAP_OFFS};
            `PTW_CFG_INT: v = {16'h0000, `PTW_INT_PIN, r.int_line};
            `PTW_CFG_PMC: v = `PTW_PMC_VALUE;
            `PTW_CFG_PMCSR: begin
                v = {16'h0000, r.pme_st, 6'h00, r.pme_en, 6'h00, r.pstate};
            end
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    function automatic logic [31:0] mem_rd(input ptw_pkg::ptw_regs_type r,
                                           input logic [9:0] idx);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (idx < 10'h008) begin
            v = {16'h0000, r.mcr[idx[2:0]], r.channel_function_control[idx[2:0]]};
        end else if (idx == `PTW_MEM_GLOBAL) begin
            v = {16'h0000, r.ien, r.pend};
        end
        return v;
    endfunction

    // ========================================================
    // next state
    always_comb begin
        logic frame_start;
        logic hit_cfg;
        logic hit_mem;
        logic wr;
        logic xfer;
        logic [3:0] be;
        logic [5:0] ci;
        logic [9:0] mi;
        logic [7:0] ev;
        frame_start = 1'b0;
        hit_cfg = 1'b0;
        hit_mem = 1'b0;
        wr = 1'b0;
        xfer = 1'b0;
        be = ~cbe_n_i;
        ci = q.addr[7:2];
        mi = q.addr[11:2];
        ev = rx_char_i | modem_chg_i;
        d = q;
        d.frame_n = frame_n_i;
        d.apar_chk = 1'b0;
        d.dpar_chk = 1'b0;
        d.serr = 1'b0;
        // read parity follows driven AD one cycle later
        d.par_o = ^{q.ad_o, cbe_n_i};
        d.par_oe = q.ad_oe;
        frame_start = q.frame_n && !frame_n_i;

        unique case (q.st)
            ptw_pkg::ST_IDLE: begin
                if (frame_start) begin
                    d.addr = ad_i;
                    d.cmd = cbe_n_i;
                    d.apar = ^{ad_i, cbe_n_i};
                    d.apar_chk = 1'b1;
                    hit_cfg = idsel_i && ad_i[1:0] == 2'h0 &&
                        (cbe_n_i == `PTW_BUS_CFG_RD ||
                         cbe_n_i == `PTW_BUS_CFG_WR);
                    hit_mem = q.cmd_reg[`PTW_CMD_MEM] &&
                        q.pstate == `PTW_D0 && ad_i[31:12] == q.bar &&
                        (cbe_n_i == `PTW_BUS_MEM_RD ||
                         cbe_n_i == `PTW_BUS_MEM_WR);
                    d.is_cfg = hit_cfg;
                    if (hit_cfg || hit_mem) begin
                        d.st = ptw_pkg::ST_CLAIM;
                        d.ctl_oe = 1'b1;
                        d.devsel_n = 1'b0;
                    end
                end
            end
            ptw_pkg::ST_CLAIM: begin
                wr = q.cmd[0];
                d.ad_oe = !wr;
                d.ad_o = q.is_cfg ? cfg_rd(q, ci) : mem_rd(q, mi);
                d.trdy_n = 1'b0;
                // single data phase: disconnect with data
                d.stop_n = 1'b0;
                d.st = ptw_pkg::ST_DATA;
            end
            ptw_pkg::ST_DATA: begin
                wr = q.cmd[0];
                xfer = !irdy_n_i;
                if (xfer) begin
                    d.st = ptw_pkg::ST_TURN;
                    d.ad_oe = 1'b0;
                    d.devsel_n = 1'b1;
                    d.trdy_n = 1'b1;
                    d.stop_n = 1'b1;
                    d.dpar = ^{ad_i, cbe_n_i};
                    d.dpar_chk = wr;
                end
            end
            ptw_pkg::ST_TURN: begin
                // release after one cycle driven high
                d.ctl_oe = 1'b0;
                d.st = ptw_pkg::ST_IDLE;
            end
        endcase

        // register writes with byte enables
        if (xfer && wr && q.is_cfg) begin
            unique case (ci)
                `PTW_CFG_CMD: begin
                    if (be[0]) d.cmd_reg[7:0] = ad_i[7:0];
                    if (be[1]) d.cmd_reg[15:8] = {5'h00, ad_i[10:8]};
                end
                `PTW_CFG_BAR0: begin
                    if (be[1]) d.bar[3:0] = ad_i[15:12];
                    if (be[2]) d.bar[11:4] = ad_i[23:16];
                    if (be[3]) d.bar[19:12] = ad_i[31:24];
                end
                `PTW_CFG_INT: begin
                    if (be[0]) d.int_line = ad_i[7:0];
                end
                `PTW_CFG_PMCSR: begin
                    if (be[0]) d.pstate = ad_i[1:0];
                    if (be[1]) d.pme_en = ad_i[`PTW_PM_EN];
                end
                default: begin
                end
            endcase
        end else if (xfer && wr) begin
            if (mi < 10'h008) begin
                if (be[0]) d.channel_function_control[mi[2:0]] = ad_i[7:0];
                if (be[1]) d.mcr[mi[2:0]] = ad_i[15:8];
            end else if (mi == `PTW_MEM_GLOBAL) begin
                if (be[0]) d.pend = q.pend & ~ad_i[7:0];
                if (be[1]) d.ien = ad_i[15:8];
            end
        end

        // write-one clears of status; events below win
        if (xfer && wr && q.is_cfg && ci == `PTW_CFG_CMD && be[3]) begin
            if (ad_i[`PTW_ST_DPERR + 16]) d.det_perr = 1'b0;
            if (ad_i[`PTW_ST_SSERR + 16]) d.sig_serr = 1'b0;
        end
        if (xfer && wr && q.is_cfg && ci == `PTW_CFG_PMCSR && be[1]) begin
            if (ad_i[`PTW_PM_ST]) d.pme_st = 1'b0;
        end

        // address parity error to system error
        if (q.apar_chk && par_i != q.apar) begin
            d.det_perr = 1'b1;
            if (q.cmd_reg[`PTW_CMD_SERR] && q.cmd_reg[`PTW_CMD_PERR]) begin
                d.serr = 1'b1;
                d.sig_serr = 1'b1;
            end
        end

        // write data parity error: low one cycle then high
        if (q.perr_cnt != 2'h0) begin
            d.perr_cnt = q.perr_cnt - 2'h1;
        end
        if (q.dpar_chk && par_i != q.dpar) begin
            d.det_perr = 1'b1;
            if (q.cmd_reg[`PTW_CMD_PERR]) d.perr_cnt = 2'h2;
        end

        // interrupt sources
        d.pend = d.pend | ev;

        if (q.pstate == `PTW_D3HOT && q.pme_en && |ev) begin
            d.pme_st = 1'b1;
        end

        // normal receive passes the idle-high line
        for (int c = 0; c < 8; c++) begin
            d.rx_out[c] = rx_i[c];
            if (q.mcr[c][`PTW_MCR_IRMODE]) begin
                d.rx_out[c] = rx_i[c] ^ q.channel_function_control[c][`PTW_CHANNEL_FUNCTION_CONTROL_IRINV];
            end
        end
    end

    // ========================================================
    // state register
    // bus reset restores defaults
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= rst_val;
        end else begin
            q <= d;
        end
    end

    // ========================================================
    // pins
    assign ad_o = q.ad_o;
    assign ad_oe_n_o = !q.ad_oe;
    assign par_o = q.par_o;
    assign par_oe_n_o = !q.par_oe;
    // target controls driven while selected and for one turnaround cycle after
    assign devsel_n_o = q.devsel_n;
    assign trdy_n_o = q.trdy_n;
    assign stop_n_o = q.stop_n;
    assign devsel_oe_n_o = !q.ctl_oe;
    assign trdy_oe_n_o = !q.ctl_oe;
    assign stop_oe_n_o = !q.ctl_oe;
    assign perr_n_o = q.perr_cnt != 2'h2;
    assign perr_oe_n_o = q.perr_cnt == 2'h0;
    assign serr_n_o = 1'b0;
    assign serr_oe_n_o = !q.serr;
    assign inta_n_o = 1'b0;
    assign inta_oe_n_o = !(|(q.pend & q.ien) &&
                           !q.cmd_reg[`PTW_CMD_INTDIS]);
    assign pme_n_o = 1'b0;
    assign pme_oe_n_o = !(q.pme_st && q.pme_en);
    assign rx_dec_o = q.rx_out;
    always_comb begin
        for (int c = 0; c < 8; c++) begin
            rts_n_o[c] = !q.mcr[c][`PTW_MCR_RTS];
        end
    end
endmodule

// ===== sim/ptw_target_props.sv
// checker on the bus target ports
`timescale 1ns/1ps

module ptw_target_props (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [31:0] ad_o,
    input wire logic ad_oe_n_o,
    input wire logic [3:0] cbe_n_i,
    input wire logic frame_n_i,
    input wire logic irdy_n_i,
    input wire logic par_o,
    input wire logic par_oe_n_o,
    input wire logic devsel_n_o,
    input wire logic devsel_oe_n_o,
    input wire logic trdy_n_o,
    input wire logic trdy_oe_n_o,
    input wire logic stop_n_o,
    input wire logic stop_oe_n_o,
    input wire logic perr_n_o,
    input wire logic perr_oe_n_o,
    input wire logic serr_n_o,
    input wire logic serr_oe_n_o,
    input wire logic inta_n_o,
    input wire logic inta_oe_n_o,
    input wire logic pme_n_o,
    input wire logic pme_oe_n_o,
    input wire logic [7:0] rx_dec_o,
    input wire logic [7:0] rts_n_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // ======
    // bus control
    a_claim_cause: assert property (
        $fell(devsel_n_o) |-> !$past(frame_n_i)) else $error("claim");
    a_ctl_idle: assert property (
        devsel_oe_n_o |-> devsel_n_o && trdy_n_o && stop_n_o
        && trdy_oe_n_o && stop_oe_n_o) else $error("released");
    a_ready_next: assert property (
        $fell(devsel_n_o) |=> !trdy_n_o && !stop_n_o) else $error("ready");
    a_ready_wait: assert property (
        !trdy_n_o && irdy_n_i |=> !trdy_n_o) else $error("wait");
    a_ready_end: assert property (
        !trdy_n_o && !irdy_n_i |=> trdy_n_o && !trdy_oe_n_o ##1 trdy_oe_n_o)
        else $error("end");
    // ======
    // parity, open drain and reset idle
    a_par_even: assert property (
        !par_oe_n_o |-> par_o == ^{$past(ad_o), $past(cbe_n_i)})
        else $error("parity");
    a_par_follow: assert property (
        $rose(ad_oe_n_o) |-> !par_oe_n_o) else $error("par drive");
    a_perr_shape: assert property (
        !perr_oe_n_o && !perr_n_o |=> !perr_oe_n_o && perr_n_o ##1 perr_oe_n_o)
        else $error("perr");
    a_serr_pulse: assert property (
        !serr_oe_n_o |=> serr_oe_n_o) else $error("serr");
    a_od_levels: assert property (
        !inta_n_o && !serr_n_o && !pme_n_o) else $error("open drain");
    a_reset_idle: assert property (disable iff (1'b0)
        !resetn_i ##1 !resetn_i |-> rts_n_o == 8'hFF && rx_dec_o == 8'hFF
        && devsel_oe_n_o
        && ad_oe_n_o) else $error("reset");
    c_read: cover property (!trdy_n_o && !irdy_n_i && !ad_oe_n_o);
    c_perr: cover property (!perr_oe_n_o);
    c_inta: cover property (!inta_oe_n_o);
    c_pme: cover property (!pme_oe_n_o);
endmodule

bind ptw_target ptw_target_props u_props (.*);

// ===== sim/ptw_host.sv
// bus initiator model: one data phase per transfer
`timescale 1ns/1ps

module ptw_host (
    input wire logic clk_i,
    input wire logic [31:0] ad_i,
    input wire logic devsel_n_i,
    input wire logic trdy_n_i,
    output logic [31:0] ad_o,
    output logic drv_o,
    output logic [3:0] cbe_n_o,
    output logic par_o,
    output logic frame_n_o,
    output logic irdy_n_o,
    output logic idsel_o
);
    logic flip, pnx, pdrv;
    // cycles the initiator waits before its last data phase is ready
    int irdy_lag = 0;
    initial begin
        {ad_o, drv_o, par_o, flip, idsel_o} = 36'h0;
        {cbe_n_o, frame_n_o, irdy_n_o} = 6'h3F;
    end
    // ======
    // parity one cycle late
    always @(posedge clk_i) begin
        pnx = ^{ad_o, cbe_n_o} ^ flip;
        pdrv = drv_o;
        #1;
        par_o = pdrv ? pnx : ~par_o;
    end
    // ======
    // transfer; bad[0] spoils address parity, bad[1] data parity
    task automatic xfer(input logic [3:0] c, be, input logic [31:0] a, d,
                        input logic sel, input logic [1:0] bad,
                        output logic [31:0] q, output logic hit);
        hit = 1'h0;
        @(posedge clk_i);
        #1;
        frame_n_o = 1'h0;
        cbe_n_o = c;
        ad_o = a;
        drv_o = 1'h1;
        idsel_o = sel;
        flip = bad[0];
        @(posedge clk_i);
        #1;
        // byte enables and data of the last data phase
        cbe_n_o = be;
        idsel_o = 1'h0;
        flip = bad[1];
        drv_o = c[0];
        ad_o = d;
        // frame held until the initiator is ready
        repeat (irdy_lag) begin
            @(posedge clk_i);
            #1;
        end
        frame_n_o = 1'h1;
        irdy_n_o = 1'h0;
        for (int n = 0; n < 8; n++) begin
            @(posedge clk_i);
            if (!devsel_n_i) hit = 1'h1;
            if (!trdy_n_i) break;
        end
        q = ad_i;
        #1;
        irdy_n_o = 1'h1;
        cbe_n_o = 4'hF;
        drv_o = 1'h0;
        flip = 1'h0;
        repeat (2) @(posedge clk_i);
    endtask
endmodule

// ===== sim/testbench.sv
// testbench: config, channel, event and parity checks
`timescale 1ns/1ps

module testbench;
    typedef struct {
        logic [3:0] c, be;
        logic [31:0] a, d, e;
        logic sel, hit;
    } ptw_row_type;
    logic clk_sys_i = 1'h0, resetn_i = 1'h0;
    logic [31:0] ad_i, ad_o, h_ad, q;
    logic [3:0] cbe_n_i;
    logic par_i, par_o, h_par, h_drv, hit, frame_n_i, irdy_n_i, idsel_i;
    logic ad_oe_n_o, par_oe_n_o, devsel_n_o, devsel_oe_n_o, trdy_n_o;
    logic trdy_oe_n_o, stop_n_o, stop_oe_n_o, perr_n_o, perr_oe_n_o;
    logic serr_n_o, serr_oe_n_o, inta_n_o, inta_oe_n_o, pme_n_o, pme_oe_n_o;
    logic [7:0] rx_char_i = 8'h0, modem_chg_i = 8'h0, rx_i = 8'hFF;
    logic [7:0] rx_dec_o, rts_n_o;
    logic perr_seen = 1'h0, serr_seen = 1'h0;
    int fails = 0, checks_done = 0;
    ptw_row_type rows[13] = '{
        '{4'hA, 4'h0, 32'h0, 32'h0, 32'h3C4D1A2B, 1'h1, 1'h1},
        '{4'hA, 4'h0, 32'h40, 32'h0, 32'h7E030001, 1'h1, 1'h1},
        '{4'hA, 4'h0, 32'h0, 32'h0, 32'h0, 1'h0, 1'h0},
        '{4'h6, 4'h0, 32'h1000, 32'h0, 32'h0, 1'h0, 1'h0},
        '{4'hB, 4'h0, 32'h10, 32'h1000, 32'h0, 1'h1, 1'h1},
        '{4'hB, 4'h0, 32'h04, 32'h142, 32'h0, 1'h1, 1'h1},
        '{4'hA, 4'h0, 32'h10, 32'h0, 32'h1000, 1'h1, 1'h1},
        '{4'h7, 4'h0, 32'h1004, 32'h4210, 32'h0, 1'h0, 1'h1},
        '{4'h6, 4'h0, 32'h1004, 32'h0, 32'h4210, 1'h0, 1'h1},
        '{4'h7, 4'hE, 32'h1000, 32'hFF02, 32'h0, 1'h0, 1'h1},
        '{4'h6, 4'h0, 32'h1000, 32'h0, 32'h2, 1'h0, 1'h1},
        '{4'h7, 4'h0, 32'h1080, 32'hFF00, 32'h0, 1'h0, 1'h1},
        '{4'h6, 4'h0, 32'h1080, 32'h0, 32'hFF00, 1'h0, 1'h1}};

    always #20 clk_sys_i = ~clk_sys_i;
    // nobody driving: the wire shows the inverse of the last value
    assign ad_i = !ad_oe_n_o ? ad_o : h_drv ? h_ad : ~h_ad;
    assign par_i = !par_oe_n_o ? par_o : h_par;
    always @(posedge clk_sys_i) begin
        if (!perr_oe_n_o && !perr_n_o) perr_seen = 1'h1;
        if (!serr_oe_n_o) serr_seen = 1'h1;
    end

    ptw_target u_dut (.*);
    ptw_host u_host (.clk_i(clk_sys_i), .ad_i(ad_i),
        .devsel_n_i(devsel_n_o | devsel_oe_n_o),
        .trdy_n_i(trdy_n_o | trdy_oe_n_o), .ad_o(h_ad), .drv_o(h_drv),
        .cbe_n_o(cbe_n_i), .par_o(h_par), .frame_n_o(frame_n_i),
        .irdy_n_o(irdy_n_i), .idsel_o(idsel_i));

    // ======
    // helpers
    task automatic chk(input logic [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic go(input ptw_row_type r, input logic [1:0] bad);
        u_host.xfer(r.c, r.be, r.a, r.d, r.sel, bad, q, hit);
        #1;
    endtask
    task automatic cfg(input logic [3:0] c, input logic [31:0] a, d,
                       input logic [1:0] bad);
        go('{c, 4'h0, a, d, 32'h0, 1'h1, 1'h1}, bad);
    endtask
    task automatic pulse(input logic [7:0] rc, mc);
        rx_char_i = rc;
        modem_chg_i = mc;
        @(posedge clk_sys_i);
        #1;
        rx_char_i = 8'h0;
        modem_chg_i = 8'h0;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic stop_test();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ======
    // main sequence
    initial begin
        repeat (8) @(posedge clk_sys_i);
        #1;
        chk(rx_dec_o, 8'hFF);
        chk(rts_n_o, 8'hFF);
        chk(devsel_oe_n_o & ad_oe_n_o & inta_oe_n_o, 1'h1);
        resetn_i = 1'h1;
        @(posedge clk_sys_i);
        #1;
        foreach (rows[i]) begin
            go(rows[i], 2'h0);
            chk(hit, rows[i].hit);
            if (!rows[i].c[0] && rows[i].hit) chk(q, rows[i].e);
        end
        // initiator wait states: target must hold ready until the transfer
        u_host.irdy_lag = 2;
        go(rows[8], 2'h0);
        chk(q, rows[8].e);
        u_host.irdy_lag = 0;
        $display("rows done");
        chk(rts_n_o, 8'hFD);
        rx_i = 8'hA5;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(rx_dec_o, 8'hA7);
        $display("serial done");
        pulse(8'h08, 8'h0);
        chk(inta_oe_n_o, 1'h0);
        chk(pme_oe_n_o, 1'h1);
        go('{4'h7, 4'hE, 32'h1080, 32'h08, 32'h0, 1'h0, 1'h1}, 2'h0);
        chk(inta_oe_n_o, 1'h1);
        cfg(4'hB, 32'h44, 32'h103, 2'h0);
        pulse(8'h0, 8'h20);
        chk(pme_oe_n_o, 1'h0);
        cfg(4'hB, 32'h44, 32'h8000, 2'h0);
        chk(pme_oe_n_o, 1'h1);
        $display("events done");
        cfg(4'hB, 32'h3C, 32'h0, 2'h2);
        chk(perr_seen, 1'h1);
        cfg(4'hA, 32'h0, 32'h0, 2'h1);
        chk(serr_seen, 1'h1);
        cfg(4'hA, 32'h04, 32'h0, 2'h0);
        chk(q[31:30], 2'h3);
        $display("parity done");
        resetn_i = 1'h0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(rts_n_o & rx_dec_o, 8'hFF);
        resetn_i = 1'h1;
        @(posedge clk_sys_i);
        #1;
        cfg(4'hA, 32'h10, 32'h0, 2'h0);
        chk(q, 32'h0);
        $display("reset done");
        stop_test();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fails++;
        stop_test();
    end
endmodule
